// >>> core/anx_regs.v
/*
  Auto-negotiation expansion and next-page transmit registers, reached over
  APB, with sticky status, an interrupt and the next-page hand-off.
  Assumes the negotiation engine runs on pclk and drives its status and
  strobes synchronously; page storage and port configuration live elsewhere.
*/
`timescale 1ns/1ns
`default_nettype none
`include "anx_defs.vh"

module anx_regs (
  input  wire        pclk,
  input  wire        presetn,
  input  wire        psel,
  input  wire        penable,
  input  wire        pwrite,
  input  wire [7:0]  paddr,
  input  wire [31:0] pwdata,
  input  wire [3:0]  pstrb,
  output reg  [31:0] prdata_q,
  output reg         pready_q,
  output reg         pslverr_q,
  output reg         irq_q,
  input  wire        an_base_page,
  input  wire        an_pd_fault,
  input  wire        an_lp_np_able,
  input  wire        an_lp_an_able,
  input  wire        an_page_stored,
  input  wire        page_arrival_variable,
  input  wire        an_tx_disable,
  input  wire        np_ack,
  output reg  [15:0] np_word_q,
  output reg         np_valid_q,
  output reg         alt_np_q
);

  // Address match for one register index; also rejects unaligned words.
  function sel_reg;
    input [7:0] addr;
    input [5:0] idx;
    begin
      sel_reg = (addr[7:2] == idx) && (addr[1:0] == 2'h0);
    end
  endfunction

  // APB phase decode shared by every register.
  wire acc_first;
  wire acc_done;
  wire wr_done;
  wire rd_done;
  assign acc_first = psel & penable & ~pready_q;
  assign acc_done  = psel & penable & pready_q;
  assign wr_done   = acc_done & pwrite;
  assign rd_done   = acc_done & ~pwrite;

  wire hit_exp;
  wire hit_npt;
  wire hit_ctrl;
  wire hit_ists;
  wire hit_imask;
  wire unmapped;
  assign hit_exp   = sel_reg(paddr, `ANX_IDX_EXP);
  assign hit_npt   = sel_reg(paddr, `ANX_IDX_NPT);
  assign hit_ctrl  = sel_reg(paddr, `ANX_IDX_CTRL);
  assign hit_ists  = sel_reg(paddr, `ANX_IDX_ISTS);
  assign hit_imask = sel_reg(paddr, `ANX_IDX_IMASK);
  assign unmapped  = ~(hit_exp | hit_npt | hit_ctrl | hit_ists | hit_imask);

  // A next-page write while the previous one waits for its
  // acknowledge is refused, so the word on the link never changes.
  wire npt_busy_wr;
  assign npt_busy_wr = pwrite & hit_npt & np_valid_q;

  // Registers held in this block.
  reg  [`ANX_IRQ_W-1:0] ists_q;
  reg  [`ANX_IRQ_W-1:0] ists_d;
  reg  [`ANX_IRQ_W-1:0] imask_q;
  reg                   last_tgl_q;
  reg                   rd_exp_q;
  reg                   arrival_prev_q;
  reg                   txdis_prev_q;

  // Sticky expansion cells: index 0 page received, 1 fault, 2 base page.
  wire [`ANX_LH_N-1:0] lh_set;
  wire [`ANX_LH_N-1:0] lh_clr;
  wire [`ANX_LH_N-1:0] lh_q;

  // Read clears only what the reader was actually shown, so an event
  // landing between the data capture and the clear is not lost.
  wire rd_clr_pgrx;
  wire rd_clr_pdf;
  wire rd_clr_base;
  assign rd_clr_pgrx = rd_exp_q & prdata_q[`ANX_EXP_PGRX];
  assign rd_clr_pdf  = rd_exp_q & prdata_q[`ANX_EXP_PDF];
  assign rd_clr_base = rd_exp_q & prdata_q[`ANX_EXP_BASEPG];

  // Extra clear of page received under the alternate next-page feature.
  wire arrival_fell;
  wire txdis_rose;
  assign arrival_fell = arrival_prev_q & ~page_arrival_variable;
  assign txdis_rose   = ~txdis_prev_q & an_tx_disable;

  // Page received sets when the stored code word is ready.
  assign lh_set[0] = an_page_stored;
  assign lh_clr[0] = rd_clr_pgrx |
                     (alt_np_q & (arrival_fell | txdis_rose));
  // Parallel detection fault is held until read.
  assign lh_set[1] = an_pd_fault;
  assign lh_clr[1] = rd_clr_pdf;
  // Base page follows the engine only with the feature on.
  assign lh_set[2] = an_base_page & alt_np_q;
  assign lh_clr[2] = rd_clr_base;

  genvar gi;
  generate
    for (gi = 0; gi < `ANX_LH_N; gi = gi + 1)
    begin : g_lh
      anx_lh_bit u_lh (
        .pclk    (pclk),
        .presetn (presetn),
        .set     (lh_set[gi]),
        .clr     (lh_clr[gi]),
        .q       (lh_q[gi])
      );
    end
  endgenerate

  // Expansion register image; reserved upper bits stay zero.
  reg [15:0] exp_rd;
  always @*
  begin
    exp_rd                  = 16'h0000;
    exp_rd[`ANX_EXP_BASEPG] = lh_q[2];
    exp_rd[`ANX_EXP_PDF]    = lh_q[1];
    exp_rd[`ANX_EXP_LPNP]   = an_lp_np_able;
    exp_rd[`ANX_EXP_NPABLE] = 1'b1;
    exp_rd[`ANX_EXP_PGRX]   = lh_q[0];
    exp_rd[`ANX_EXP_LPAN]   = an_lp_an_able;
  end

  // Read multiplexer; narrow registers sit in the low bits.
  reg [31:0] rd_mux;
  always @*
  begin
    rd_mux = 32'h0000_0000;
    if (hit_exp)
      rd_mux[15:0] = exp_rd;
    else if (hit_npt)
      rd_mux[15:0] = np_word_q & `ANX_NPT_WMASK;
    else if (hit_ctrl)
      rd_mux[`ANX_CTRL_ALTNP] = alt_np_q;
    else if (hit_ists)
      rd_mux[`ANX_IRQ_W-1:0] = ists_q;
    else if (hit_imask)
      rd_mux[`ANX_IRQ_W-1:0] = imask_q;
  end

  // Every access takes one wait state: pready rises in the second
  // access cycle, which keeps all bus outputs straight from flops.
  always @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      pready_q  <= 1'b0;
      pslverr_q <= 1'b0;
      prdata_q  <= 32'h0000_0000;
    end
    else
    begin
      pready_q  <= acc_first;
      pslverr_q <= acc_first & (unmapped | npt_busy_wr);
      if (acc_first & ~pwrite)
        prdata_q <= rd_mux;
    end
  end

  // Mark a completed expansion read so its bits are cleared next edge.
  always @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      rd_exp_q <= 1'b0;
    else
      rd_exp_q <= rd_done & hit_exp;
  end

  // Edge history for the alternate next-page clear conditions.
  always @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      arrival_prev_q <= 1'b0;
      txdis_prev_q   <= 1'b0;
    end
    else
    begin
      arrival_prev_q <= page_arrival_variable;
      txdis_prev_q   <= an_tx_disable;
    end
  end

  // Control register: the alternate next-page enable steers the engine.
  always @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      alt_np_q <= `ANX_CTRL_RST;
    else if (wr_done & hit_ctrl & pstrb[0])
      alt_np_q <= pwdata[`ANX_CTRL_ALTNP];
  end

  // Next-page write lands only if its access phase did not refuse it.
  wire npt_wr;
  wire np_taken;
  wire tgl_bad;
  wire [15:0] npt_wdata;
  assign npt_wr   = wr_done & hit_npt & ~pslverr_q;
  assign npt_wdata = pwdata[15:0] & `ANX_NPT_WMASK;
  assign np_taken = np_ack & np_valid_q;
  // A toggle equal to the one last sent would look like a repeat page.
  assign tgl_bad  = npt_wr & pstrb[1] &
                    (pwdata[`ANX_NPT_TGL] == last_tgl_q);

  // Next-page transmit register doubles as the word handed to the engine.
  // Software owns the field meanings; hardware only forces bit 14 low.
  always @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      np_word_q <= `ANX_NPT_RST;
    else if (npt_wr)
    begin
      if (pstrb[0])
        np_word_q[7:0] <= pwdata[7:0];
      if (pstrb[1])
        np_word_q[15:8] <= npt_wdata[15:8];
    end
  end

  // Page is offered from the write until the partner acknowledges it.
  always @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      np_valid_q <= 1'b0;
    else if (npt_wr)
      np_valid_q <= 1'b1;
    else if (np_taken)
      np_valid_q <= 1'b0;
  end

  // Remember the toggle actually sent; reset to one so that the first
  // next page, whose toggle resets to zero, is accepted as alternating.
  always @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      last_tgl_q <= 1'b1;
    else if (np_taken)
      last_tgl_q <= np_word_q[`ANX_NPT_TGL];
  end

  // Interrupt status: events set, write one to clear, set wins.
  reg [`ANX_IRQ_W-1:0] ists_set;
  reg [`ANX_IRQ_W-1:0] ists_clr;
  always @*
  begin
    ists_set = {`ANX_IRQ_W{1'b0}};
    ists_set[`ANX_IRQ_PGRX]   = an_page_stored;
    ists_set[`ANX_IRQ_PDF]    = an_pd_fault;
    ists_set[`ANX_IRQ_NPACK]  = np_taken;
    ists_set[`ANX_IRQ_TGLERR] = tgl_bad;
    ists_clr = {`ANX_IRQ_W{1'b0}};
    if (wr_done & hit_ists & pstrb[0])
      ists_clr = pwdata[`ANX_IRQ_W-1:0];
    ists_d = (ists_q & ~ists_clr) | ists_set;
  end

  always @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      ists_q <= `ANX_IRQ_RST;
    else
      ists_q <= ists_d;
  end

  // Mask register, same layout as the status register.
  always @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      imask_q <= `ANX_IRQ_RST;
    else if (wr_done & hit_imask & pstrb[0])
      imask_q <= pwdata[`ANX_IRQ_W-1:0];
  end

  // Level interrupt, one cycle behind the status it reflects.
  always @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      irq_q <= 1'b0;
    else
      irq_q <= |(ists_q & imask_q);
  end

endmodule

`default_nettype wire

// >>> pkg/anx_defs.vh
/*
  Constants for the auto-negotiation expansion and next-page register bank:
  register indexes, field positions, reset values and the interrupt layout.
  Assumes inclusion by bare name from the design files under core/.
*/
`ifndef ANX_DEFS_VH
`define ANX_DEFS_VH

// Register indexes; the byte address is four times the index.
`define ANX_IDX_EXP      6'h06
`define ANX_IDX_NPT      6'h07
`define ANX_IDX_CTRL     6'h10
`define ANX_IDX_ISTS     6'h11
`define ANX_IDX_IMASK    6'h12

// Expansion register field positions.
`define ANX_EXP_BASEPG   5
`define ANX_EXP_PDF      4
`define ANX_EXP_LPNP     3
`define ANX_EXP_NPABLE   2
`define ANX_EXP_PGRX     1
`define ANX_EXP_LPAN     0

// Next-page transmit register fields, reset value and writable mask.
`define ANX_NPT_MORE     15
`define ANX_NPT_RSVD     14
`define ANX_NPT_MSG      13
`define ANX_NPT_COMPLY   12
`define ANX_NPT_TGL      11
`define ANX_NPT_RST      16'h2001
`define ANX_NPT_WMASK    16'hBFFF

// Control register: alternate next-page feature enable.
`define ANX_CTRL_ALTNP   0
`define ANX_CTRL_RST     1'h0

// Interrupt status and mask layout.
`define ANX_IRQ_W        4
`define ANX_IRQ_PGRX     0
`define ANX_IRQ_PDF      1
`define ANX_IRQ_NPACK    2
`define ANX_IRQ_TGLERR   3
`define ANX_IRQ_RST      4'h0

// Number of sticky-until-read cells in the expansion register.
`define ANX_LH_N         3

`endif

// >>> core/anx_lh_bit.v
/*
  One sticky-until-read status cell: set by a hardware event, cleared by a
  separate clear request, with the set taking priority.
  Assumes set and clear come from logic on pclk.
*/
`timescale 1ns/1ns
`default_nettype none

module anx_lh_bit (
  input  wire pclk,
  input  wire presetn,
  input  wire set,
  input  wire clr,
  output reg  q
);

  // An event in the clearing cycle must survive, so set is tested first.
  always @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      q <= 1'b0;
    else if (set)
      q <= 1'b1;
    else if (clr)
      q <= 1'b0;
  end

endmodule

`default_nettype wire

// >>> tb/anx_eng_model.sv
/* Negotiation engine stand-in: acknowledges an offered next page.
   Assumes np_valid_q comes from anx_regs on the same pclk. */
`timescale 1ns/1ns
`default_nettype none
module anx_eng_model (
  input  wire logic       pclk,
  input  wire logic       presetn,
  input  wire logic       np_valid_q,
  input  wire logic [3:0] ack_dly,
  output logic            np_ack
);
  logic [3:0] cnt_q;

  // Ack comes ack_dly plus one cycles after the offer, so fast and slow partners
  // both occur; one pulse per offer only.
  always @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      cnt_q  <= 4'h0;
      np_ack <= 1'b0;
    end
    else
    begin
      np_ack <= np_valid_q && !np_ack && cnt_q == ack_dly;
      cnt_q  <= (np_valid_q && !np_ack) ? cnt_q + 4'h1 : 4'h0;
    end
  end
endmodule
`default_nettype wire

// >>> tb/anx_regs_props.sv
/* Port checker for the register bank.
   Assumes the bind below attaches it to every anx_regs instance. */
`timescale 1ns/1ns
`default_nettype none
module anx_regs_props (
  input wire logic        pclk,
  input wire logic        presetn,
  input wire logic        psel,
  input wire logic        penable,
  input wire logic        pwrite,
  input wire logic [7:0]  paddr,
  input wire logic [31:0] prdata_q,
  input wire logic        pready_q,
  input wire logic        pslverr_q,
  input wire logic        np_ack,
  input wire logic [15:0] np_word_q,
  input wire logic        np_valid_q
);
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);

  // First access cycle, and a completed read of the expansion register.
  sequence acc_first;
    psel && penable && $rose(penable);
  endsequence
  sequence exp_rd;
    pready_q && !pwrite && paddr == 8'h18;
  endsequence

  chk_one_wait: assert property (acc_first |-> !pready_q ##1 pready_q)
    else $error("pready not in second access cycle");
  chk_pready_pulse: assert property (pready_q |=> !pready_q)
    else $error("pready longer than one cycle");
  chk_rsvd_exp: assert property (exp_rd |-> prdata_q[31:6] == 26'h0)
    else $error("expansion reserved bits not zero");
  chk_np_able: assert property (exp_rd |-> prdata_q[2])
    else $error("local next-page ability bit low");
  chk_npt_rsvd: assert property (np_word_q[14] == 1'b0)
    else $error("next-page bit 14 set");
  chk_np_hold: assert property (np_valid_q && !np_ack |=>
    np_valid_q && $stable(np_word_q))
    else $error("offered page changed before ack");
  chk_ack_clear: assert property (np_valid_q && np_ack |=> !np_valid_q)
    else $error("offer not withdrawn after ack");
  chk_busy_err: assert property (pready_q && pwrite &&
    paddr == 8'h1C && np_valid_q |-> pslverr_q)
    else $error("write to pending page not refused");
  chk_bad_addr: assert property (pready_q && paddr == 8'h20 |-> pslverr_q)
    else $error("unmapped address not refused");
endmodule
bind anx_regs anx_regs_props u_props (.pclk(pclk), .presetn(presetn),
  .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
  .prdata_q(prdata_q), .pready_q(pready_q), .pslverr_q(pslverr_q),
  .np_ack(np_ack), .np_word_q(np_word_q), .np_valid_q(np_valid_q));
`default_nettype wire

// >>> tb/anx_regs_test.sv
/* Self-checking bench for anx_regs with an engine model.
   Assumes the design, checker and model are compiled before it. */
`timescale 1ns/1ns
`default_nettype none
module anx_regs_test;
  logic        pclk, presetn, psel, penable, pwrite;
  logic [7:0]  paddr;
  logic [31:0] pwdata, prdata_q, rdat, v, seed;
  logic        pready_q, pslverr_q, irq_q, perr, np_ack, np_valid_q, alt_np_q;
  logic        base, pdf, lpnp, lpan, stored, arrive, txdis, tgl;
  logic [15:0] np_word_q;
  logic [3:0]  ack_dly;
  int          num_errors, tests_run, i;

  anx_regs dut (.pclk(pclk), .presetn(presetn), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
    .pstrb(4'hF), .prdata_q(prdata_q), .pready_q(pready_q),
    .pslverr_q(pslverr_q), .irq_q(irq_q), .an_base_page(base),
    .an_pd_fault(pdf), .an_lp_np_able(lpnp), .an_lp_an_able(lpan),
    .an_page_stored(stored), .page_arrival_variable(arrive),
    .an_tx_disable(txdis), .np_ack(np_ack), .np_word_q(np_word_q),
    .np_valid_q(np_valid_q), .alt_np_q(alt_np_q));
  anx_eng_model u_eng (.pclk(pclk), .presetn(presetn),
    .np_valid_q(np_valid_q), .ack_dly(ack_dly), .np_ack(np_ack));

  // Expected expansion word from the engine state the bench set up.
  function automatic logic [31:0] expx(logic n, a, f, g, b);
    return {26'h0, b, f, n, 1'b1, g, a};
  endfunction

  task automatic chk(string name, logic [31:0] e, logic [31:0] g);
    tests_run++;
    if (g !== e)
    begin
      num_errors++;
      $display("mismatch %s expected %h seen %h", name, e, g);
    end
  endtask

  // One APB transfer; only the watchdog ends a wait on pready, and the
  // number of access cycles is checked against the single wait state.
  task automatic apb(logic w, logic [7:0] a, logic [31:0] d);
    int n;
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    n = 0;
    do
    begin
      @(posedge pclk);
      n++;
    end while (!pready_q);
    chk("pready_wait", 2, n);
    rdat = prdata_q;
    perr = pslverr_q;
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge pclk);
  endtask

  task automatic summarize;
    $display("checks %0d errors %0d", tests_run, num_errors);
    if (num_errors == 0 && tests_run > 0)
      $display("TB: PASS");
    else
      $display("TB: FAIL");
    $finish;
  endtask

  // Free-running 125 MHz clock.
  initial
  begin
    pclk = 0;
    forever #4 pclk = ~pclk;
  end

  // Watchdog: the sequence needs well under a thousand cycles.
  initial
  begin
    repeat (5000) @(posedge pclk);
    num_errors++;
    summarize;
  end

  // Main sequence: status flags, interrupt, next-page hand-off, errors.
  initial
  begin
    seed = 32'h1bbcfa1b;
    tgl = 1'b1;
    {presetn, psel, penable, pwrite, paddr, pwdata} <= '0;
    {base, pdf, lpnp, lpan, stored, arrive, txdis} <= '0;
    ack_dly <= 4'h8;
    repeat (20) @(posedge pclk);
    presetn <= 1'b1;
    @(posedge pclk);
    chk("np_word", 32'h2001, {16'h0, np_word_q});
    apb(1, 8'h18, 32'h0);
    apb(0, 8'h18, 0);
    chk("exp_rst", expx(0,0,0,0,0), rdat);
    lpnp <= 1;
    lpan <= 1;
    apb(0, 8'h18, 0);
    chk("exp_lp", expx(1,1,0,0,0), rdat);
    lpnp <= 0;
    lpan <= 0;
    apb(1, 8'h48, 1);
    // Base page offered while the feature is off must not latch.
    pdf <= 1;
    stored <= 1;
    base <= 1;
    @(posedge pclk);
    pdf <= 0;
    stored <= 0;
    base <= 0;
    repeat (2) @(posedge pclk);
    chk("irq_on", 1, irq_q);
    apb(0, 8'h18, 0);
    chk("exp_lh", expx(0,0,1,1,0), rdat);
    apb(0, 8'h18, 0);
    chk("exp_clr", expx(0,0,0,0,0), rdat);
    apb(1, 8'h44, 32'hF);
    // The interrupt trails the cleared status by one more edge.
    @(posedge pclk);
    chk("irq_off", 0, irq_q);
    apb(1, 8'h48, 0);
    stored <= 1;
    @(posedge pclk);
    stored <= 0;
    repeat (2) @(posedge pclk);
    chk("irq_mask", 0, irq_q);
    apb(1, 8'h40, 1);
    chk("alt_np", 1, alt_np_q);
    base <= 1;
    arrive <= 1;
    @(posedge pclk);
    base <= 0;
    arrive <= 0;
    repeat (2) @(posedge pclk);
    apb(0, 8'h18, 0);
    chk("exp_alt", expx(0,0,0,0,1), rdat);
    stored <= 1;
    @(posedge pclk);
    stored <= 0;
    txdis <= 1;
    repeat (2) @(posedge pclk);
    apb(0, 8'h18, 0);
    chk("exp_txd", expx(0,0,0,0,0), rdat);
    txdis <= 0;
    // Pages follow the software rules: alternating toggle, bit 14 low,
    // more-pages set on all but the last one.
    for (i = 0; i < 4; i++)
    begin
      v = $random(seed);
      v[15] = (i != 3);
      v[14] = 1'b0;
      v[11] = ~tgl;
      tgl = v[11];
      ack_dly <= 4'h6 + i[3:0];
      apb(1, 8'h1C, v);
      chk("np_err", 0, perr);
      chk("np_word", {16'h0, v[15:0] & 16'hBFFF}, np_word_q);
      chk("np_valid", 1, np_valid_q);
      apb(1, 8'h1C, v ^ 32'h0000_BBFF);
      chk("np_busy", 1, perr);
      repeat (16) @(posedge pclk);
      chk("np_done", 0, np_valid_q);
      apb(0, 8'h1C, 0);
      chk("np_rd", v[15:0] & 16'hBFFF, rdat);
    end
    apb(0, 8'h44, 0);
    chk("tgl_ok", 0, rdat[3]);
    apb(1, 8'h44, 32'hF);
    // A page that repeats the last sent toggle must raise the error flag.
    v[11] = tgl;
    apb(1, 8'h1C, v);
    apb(0, 8'h44, 0);
    chk("tgl_err", 32'h8, rdat);
    apb(0, 8'h20, 0);
    chk("bad_err", 1, perr);
    summarize;
  end
endmodule
`default_nettype wire
